// *** hw/csi_axil.sv ***
// axi4-lite slave that turns bus transfers into register pulses
// assumes an asynchronous active-low reset already released cleanly
`timescale 1ns/10ps
module csi_axil
  import csi_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // axi4-lite
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // register side
  csi_reg_if.bus rif
);
  logic aw_full; // write address held
  logic w_full; // write data held
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr; // both halves present, response slot free

  assign o_awready = !aw_full;
  assign o_wready = !w_full;
  assign o_arready = !o_rvalid;
  assign do_wr = aw_full && w_full && !o_bvalid;
  assign rif.wr_en = do_wr;
  assign rif.wr_addr = aw_addr;
  assign rif.wdata = w_data;
  assign rif.wstrb = w_strb;
  assign rif.rd_addr = i_araddr;

  // capture address and data in either order, answer once both are in
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `CSI_RESP_OK;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_full <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_full <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_wr) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= rif.wr_ok ? `CSI_RESP_OK : `CSI_RESP_ERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= `CSI_RESP_OK;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= rif.rd_ok ? rif.rdata : 32'h0;
      o_rresp <= rif.rd_ok ? `CSI_RESP_OK : `CSI_RESP_ERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end
endmodule

// *** hw/csi_consts.svh ***
// offsets, field positions, reset values and widths of the converter serial interface
// assumes inclusion by the package and by the design files
`ifndef CSI_CONSTS_SVH
`define CSI_CONSTS_SVH
`define CSI_AW 8
`define CSI_DW 32
`define CSI_WORD 16
`define CSI_NBUF 4
`define CSI_OFS_CTRL1 8'h00
`define CSI_OFS_CTRL2 8'h04
`define CSI_OFS_CTRL3 8'h08
`define CSI_OFS_STAT 8'h0c
`define CSI_OFS_RX0 8'h10
`define CSI_OFS_TX0 8'h20
`define CSI_B_EN 0
`define CSI_B_FSD 1
`define CSI_B_MODE 2
`define CSI_B_SCKD 4
`define CSI_B_IDLE 5
`define CSI_B_BCG 16
`define CSI_B_WLEN 0
`define CSI_B_FLEN 4
`define CSI_B_BLEN 16
`define CSI_B_TXE 0
`define CSI_B_RXF 1
`define CSI_B_ROV 2
`define CSI_B_TUN 3
`define CSI_B_SLOT 4
`define CSI_B_PTR 8
`define CSI_RST_CTRL1 32'h0000_0000
`define CSI_RST_CTRL2 32'h0000_000f
`define CSI_RST_CTRL3 32'h0003_ffff
`define CSI_AC_WLEN 4'hf
`define CSI_AC_FLEN 4'hf
`define CSI_RESP_OK 2'h0
`define CSI_RESP_ERR 2'h2
`endif

// *** hw/csi_pkg.sv ***
// types and shared helpers of the converter serial interface
// assumes csi_consts.svh is on the include path
`include "csi_consts.svh"
package csi_pkg;
  // link format selected by the mode field
  typedef enum logic [1:0] {CSI_MULTI, CSI_I2S, CSI_AC16, CSI_AC20} csi_mode_e;
  typedef logic [`CSI_WORD-1:0] csi_word_t;

  // true when the byte address names a register
  function automatic logic csi_mapped(input logic [`CSI_AW-1:0] a);
    csi_mapped = (a[1:0] == 2'h0) && (a <= 8'h2c);
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] csi_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      csi_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction
endpackage

// *** hw/csi_reg_if.sv ***
// register access carrier between the bus slave and the serial core
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface csi_reg_if;
  logic wr_en; // one-cycle write pulse
  logic [7:0] wr_addr; // write byte address
  logic [31:0] wdata; // write data
  logic [3:0] wstrb; // byte lanes
  logic wr_ok; // write address is mapped
  logic [7:0] rd_addr; // read byte address
  logic [31:0] rdata; // read data for rd_addr
  logic rd_ok; // read address is mapped
  modport bus (output wr_en, wr_addr, wdata, wstrb, rd_addr, input wr_ok, rdata, rd_ok);
  modport regs (input wr_en, wr_addr, wdata, wstrb, rd_addr, output wr_ok, rdata, rd_ok);
endinterface

// *** hw/csi_top.sv ***
// converter serial interface: bit clock, frame sync, shift path and shadow buffers
// assumes pins are asynchronous to i_clk and an axi4-lite master on the bus
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module csi_top
  import csi_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // axi4-lite register bus
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // serial bit clock pin
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_b,
  // serial data pins
  output logic o_sdo,
  output logic o_sdo_oe_b,
  input wire logic i_sdi,
  // frame sync pin
  input wire logic i_fs,
  output logic o_fs,
  output logic o_fs_oe_b
);
  csi_reg_if rif ();

  logic [1:0] rst_sync; // reset release chain
  logic rst_b; // synchronised reset
  logic [31:0] ctrl1; // enable, directions, mode, divider
  logic [31:0] ctrl2; // word and frame length
  logic [31:0] ctrl3; // transmit slot mask, buffer count
  csi_word_t txbuf [`CSI_NBUF]; // software transmit buffers
  csi_word_t rxbuf [`CSI_NBUF]; // software receive buffers
  csi_word_t tx_sh [`CSI_NBUF]; // transmit shadows
  csi_word_t rx_sh [`CSI_NBUF]; // receive shadows
  logic tx_empty, rx_full, rx_ovf, tx_unf; // status flags
  logic [1:0] sck_s, sdi_s, fs_s; // pin synchronisers
  logic sck_d; // previous synchronised bit clock
  logic fs_prev; // frame sync level at previous tick
  logic [11:0] gen_cnt; // bit clock divider
  logic sck_gen; // generated bit clock
  logic gen_tgl; // divider toggles this cycle
  logic rise, fall; // bit clock edge events
  logic busy; // a frame is under way
  logic [3:0] bit_cnt, slot_cnt; // current bit and slot
  logic [1:0] ptr; // shadow word pointer
  csi_word_t tx_sr, rx_sr; // shift registers
  logic sdo_drv; // data out driven for the current bit

  // control fields
  logic en, fsd, sckd, idle_z;
  csi_mode_e mode;
  logic [11:0] bcg;
  logic [3:0] wl, fl;
  logic [1:0] blen;
  logic aclink;
  assign en = ctrl1[`CSI_B_EN];
  assign fsd = ctrl1[`CSI_B_FSD];
  assign mode = csi_mode_e'(ctrl1[`CSI_B_MODE +: 2]);
  assign sckd = ctrl1[`CSI_B_SCKD];
  assign idle_z = ctrl1[`CSI_B_IDLE];
  assign bcg = ctrl1[`CSI_B_BCG +: 12];
  assign aclink = (mode == CSI_AC16) || (mode == CSI_AC20);
  assign wl = aclink ? `CSI_AC_WLEN : ctrl2[`CSI_B_WLEN +: 4];
  assign fl = aclink ? `CSI_AC_FLEN : ctrl2[`CSI_B_FLEN +: 4];
  assign blen = ctrl3[`CSI_B_BLEN +: 2];

  // reset release through two flip-flops
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_b = rst_sync[1];

  // bus slave
  csi_axil u_axil (
    .i_clk(i_clk),
    .i_rst_b(rst_b),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .rif(rif)
  );

  // pin synchronisers, second stage is the only reader of the first
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_s <= 2'h0;
      sdi_s <= 2'h0;
      fs_s <= 2'h0;
    end else begin
      sck_s <= {sck_s[0], i_sck};
      sdi_s <= {sdi_s[0], i_sdi};
      fs_s <= {fs_s[0], i_fs};
    end
  end

  // bit clock divider, half period of bcg+1 cycles, idle while disabled
  assign gen_tgl = en && !sckd && (bcg != 12'h0) && (gen_cnt == bcg);
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_cnt <= 12'h0;
      sck_gen <= 1'b0;
      sck_d <= 1'b0;
    end else if (!en || sckd || bcg == 12'h0) begin
      gen_cnt <= 12'h0;
      sck_gen <= 1'b0;
      sck_d <= sck_s[1];
    end else begin
      gen_cnt <= gen_tgl ? 12'h0 : gen_cnt + 12'h1;
      sck_gen <= sck_gen ^ gen_tgl;
      sck_d <= sck_s[1];
    end
  end

  // edge events from the generated or the external clock
  always_comb begin
    if (!en) begin
      rise = 1'b0;
      fall = 1'b0;
    end else if (sckd) begin
      rise = sck_s[1] && !sck_d;
      fall = !sck_s[1] && sck_d;
    end else begin
      rise = gen_tgl && !sck_gen;
      fall = gen_tgl && sck_gen;
    end
  end

  // frame position helpers
  logic last_bit, last_word, trig, word_end, start, swap;
  logic [1:0] next_ptr;
  csi_word_t load_word;
  assign last_bit = (bit_cnt == wl);
  assign last_word = last_bit && (slot_cnt == fl);
  assign word_end = rise && busy && last_bit;
  // slave start: level for multi-channel and ac-link, either edge for i2s
  assign trig = fsd && (!busy || last_word) &&
                ((mode == CSI_I2S) ? (fs_s[1] != fs_prev) : fs_s[1]);
  assign start = rise && (trig || (!fsd && !busy) || (!fsd && last_word));
  assign swap = word_end && (ptr == blen);
  assign next_ptr = word_end ? (swap ? 2'h0 : ptr + 2'h1) : ptr;
  assign load_word = swap ? txbuf[0] : tx_sh[next_ptr];

  // bit and slot counters, frame state
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      bit_cnt <= 4'h0;
      slot_cnt <= 4'h0;
      fs_prev <= 1'b0;
    end else if (!en) begin
      busy <= 1'b0;
      bit_cnt <= 4'h0;
      slot_cnt <= 4'h0;
      fs_prev <= 1'b0;
    end else if (rise) begin
      fs_prev <= fs_s[1];
      if (start) begin
        busy <= 1'b1;
        bit_cnt <= 4'h0;
        slot_cnt <= 4'h0;
      end else if (busy && last_word) begin
        busy <= 1'b0; // slave waits for the next sync
        bit_cnt <= 4'h0;
        slot_cnt <= 4'h0;
      end else if (busy && last_bit) begin
        bit_cnt <= 4'h0;
        slot_cnt <= slot_cnt + 4'h1;
      end else if (busy) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // master frame sync waveform; it leads the data by one bit, so a slave codec
  // starts its frame or word one bit clock after it sees the sync
  logic fs_next;
  logic [3:0] nslot; // slot of the bit that follows this edge
  logic [3:0] nbit; // bit of the word that follows this edge
  logic [3:0] fslot; // slot of the bit after that one
  assign nslot = (start || (busy && last_word)) ? 4'h0 :
                 (busy && last_bit) ? slot_cnt + 4'h1 : slot_cnt;
  assign nbit = (start || (busy && last_bit)) ? 4'h0 : bit_cnt + 4'h1;
  assign fslot = (nbit != wl) ? nslot : (nslot == fl) ? 4'h0 : nslot + 4'h1;
  always_comb begin
    unique case (mode)
      CSI_MULTI: fs_next = busy && (nbit == wl) && (nslot == fl);
      CSI_I2S: fs_next = (fslot > (fl >> 1));
      CSI_AC16, CSI_AC20: fs_next = (fslot == 4'h0); // last frame bit and 15 of slot zero
    endcase
  end
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_fs <= 1'b0;
    end else if (!en || fsd) begin
      o_fs <= 1'b0;
    end else if (rise) begin
      o_fs <= fs_next;
    end
  end

  // transmit shift register, msb first, low bits of short words never reach the pin
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_sr <= '0;
      sdo_drv <= 1'b0;
    end else if (!en) begin
      tx_sr <= '0;
      sdo_drv <= 1'b0;
    end else if (rise) begin
      if (start || (busy && last_bit && !last_word)) begin
        tx_sr <= load_word;
        sdo_drv <= ctrl3[nslot];
      end else if (busy && !last_bit) begin
        tx_sr <= {tx_sr[14:0], 1'b0};
      end else begin
        sdo_drv <= 1'b0;
      end
    end
  end

  // receive shift register sampled at the falling edge
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sr <= '0;
    end else if (!en || word_end) begin
      rx_sr <= '0;
    end else if (fall && busy) begin
      rx_sr <= {rx_sr[14:0], sdi_s[1]};
    end
  end

  // shadow pointer and shadow exchange at word boundaries
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr <= 2'h0;
      for (int i = 0; i < `CSI_NBUF; i++) begin
        tx_sh[i] <= '0;
        rx_sh[i] <= '0;
      end
    end else if (!en) begin
      ptr <= 2'h0;
    end else if (word_end) begin
      ptr <= next_ptr;
      rx_sh[ptr] <= rx_sr << (4'hf - wl);
      if (swap) begin
        for (int i = 0; i < `CSI_NBUF; i++) begin
          tx_sh[i] <= txbuf[i];
        end
      end
    end
  end

  // software buffers: receive copied in on the same edge that fills the last shadow
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `CSI_NBUF; i++) begin
        rxbuf[i] <= '0;
      end
    end else if (swap) begin
      for (int i = 0; i < `CSI_NBUF; i++) begin
        rxbuf[i] <= (i[1:0] == ptr) ? csi_word_t'(rx_sr << (4'hf - wl)) : rx_sh[i];
      end
    end
  end

  // register writes
  logic wr_ctl1, wr_ctl2, wr_ctl3, wr_stat, wr_tx;
  logic [1:0] wr_idx;
  assign wr_ctl1 = rif.wr_en && rif.wr_addr == `CSI_OFS_CTRL1;
  assign wr_ctl2 = rif.wr_en && rif.wr_addr == `CSI_OFS_CTRL2;
  assign wr_ctl3 = rif.wr_en && rif.wr_addr == `CSI_OFS_CTRL3;
  assign wr_stat = rif.wr_en && rif.wr_addr == `CSI_OFS_STAT;
  assign wr_tx = rif.wr_en && rif.wr_addr[7:4] == `CSI_OFS_TX0 >> 4 && rif.wr_addr[1:0] == 2'h0;
  assign wr_idx = rif.wr_addr[3:2];
  assign rif.wr_ok = csi_mapped(rif.wr_addr);
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1 <= `CSI_RST_CTRL1;
      ctrl2 <= `CSI_RST_CTRL2;
      ctrl3 <= `CSI_RST_CTRL3;
    end else begin
      if (wr_ctl1) ctrl1 <= csi_merge(ctrl1, rif.wdata, rif.wstrb);
      if (wr_ctl2) ctrl2 <= csi_merge(ctrl2, rif.wdata, rif.wstrb);
      if (wr_ctl3) ctrl3 <= csi_merge(ctrl3, rif.wdata, rif.wstrb);
    end
  end

  // transmit buffers written by software only
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `CSI_NBUF; i++) begin
        txbuf[i] <= '0;
      end
    end else if (wr_tx) begin
      txbuf[wr_idx] <= csi_word_t'(csi_merge({16'h0, txbuf[wr_idx]}, rif.wdata, rif.wstrb));
    end
  end

  // status flags, a hardware set beats a software clear in the same cycle
  logic clr_rxf, clr_rov, clr_tun, clr_txe;
  assign clr_rxf = wr_stat && rif.wstrb[0] && rif.wdata[`CSI_B_RXF];
  assign clr_rov = wr_stat && rif.wstrb[0] && rif.wdata[`CSI_B_ROV];
  assign clr_tun = wr_stat && rif.wstrb[0] && rif.wdata[`CSI_B_TUN];
  assign clr_txe = wr_tx && wr_idx == blen;
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_empty <= 1'b1;
      rx_full <= 1'b0;
      rx_ovf <= 1'b0;
      tx_unf <= 1'b0;
    end else if (swap) begin
      tx_empty <= 1'b1;
      rx_full <= 1'b1;
      rx_ovf <= rx_ovf || rx_full;
      tx_unf <= tx_unf || tx_empty;
    end else begin
      if (clr_txe) tx_empty <= 1'b0;
      if (clr_rxf) rx_full <= 1'b0;
      if (clr_rov) rx_ovf <= 1'b0;
      if (clr_tun) tx_unf <= 1'b0;
    end
  end

  // register reads
  assign rif.rd_ok = csi_mapped(rif.rd_addr);
  always_comb begin
    rif.rdata = 32'h0;
    if (rif.rd_addr == `CSI_OFS_CTRL1) begin
      rif.rdata = ctrl1;
    end else if (rif.rd_addr == `CSI_OFS_CTRL2) begin
      rif.rdata = ctrl2;
    end else if (rif.rd_addr == `CSI_OFS_CTRL3) begin
      rif.rdata = ctrl3;
    end else if (rif.rd_addr == `CSI_OFS_STAT) begin
      rif.rdata[`CSI_B_TXE] = tx_empty;
      rif.rdata[`CSI_B_RXF] = rx_full;
      rif.rdata[`CSI_B_ROV] = rx_ovf;
      rif.rdata[`CSI_B_TUN] = tx_unf;
      rif.rdata[`CSI_B_SLOT +: 4] = slot_cnt;
      rif.rdata[`CSI_B_PTR +: 2] = ptr;
    end else if (rif.rd_addr[7:4] == `CSI_OFS_RX0 >> 4) begin
      rif.rdata[15:0] = rxbuf[rif.rd_addr[3:2]];
    end else if (rif.rd_addr[7:4] == `CSI_OFS_TX0 >> 4) begin
      rif.rdata[15:0] = txbuf[rif.rd_addr[3:2]];
    end
  end

  // pin drive; enables are low while driving, released when disabled
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_sck <= 1'b0;
      o_sdo <= 1'b0;
    end else begin
      o_sck <= sck_gen;
      o_sdo <= en && sdo_drv && tx_sr[15];
    end
  end
  assign o_sck_oe_b = !(en && !sckd);
  assign o_sdo_oe_b = !(en && (sdo_drv || !idle_z));
  assign o_fs_oe_b = !(en && !fsd);
endmodule

// *** sim/csi_codec_model.sv ***
// behavioural codec on the far side of the pins: eight-bit words, four slots
// assumes multi-channel framing, sync high in the bit before slot zero
`timescale 1ns/10ps
module csi_codec_model (
  // pins as seen on the board
  input wire logic i_sck,
  input wire logic i_sdo,
  input wire logic i_sdo_oe_b,
  input wire logic i_fs,
  output logic o_sdi,
  // words to send and words caught, slot zero in the top byte
  input wire logic [31:0] i_send,
  output logic [31:0] o_got
);
  int pos = 99; // bit of the frame, parked until the first sync
  logic fs_seen = 1'b0; // sync caught in the bit just ended
  initial o_got = 32'h0;
  initial o_sdi = 1'b0;
  // catch data mid bit; a released data line reads high through its pull-up
  always @(negedge i_sck) begin
    fs_seen = i_fs;
    if (pos < 32) o_got[31 - pos] = i_sdo_oe_b ? 1'b1 : i_sdo;
  end
  // launch the next bit msb first on the rising bit clock
  always @(posedge i_sck) begin
    pos = fs_seen ? 0 : pos + 1;
    o_sdi = i_send[31 - (pos % 32)];
  end
endmodule

// *** sim/csi_top_asserts.sv ***
// assertions on the ports of the converter serial interface top
// assumes a bind to csi_top and one clock domain
`timescale 1ns/10ps
module csi_top_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register bus
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  // pins
  input wire logic o_sck,
  input wire logic o_sck_oe_b,
  input wire logic o_sdo_oe_b,
  input wire logic o_fs_oe_b
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic en, sckd, fsd, idle; // control bits as last written
  logic [11:0] bcg; // divider as last written
  // shadow the first control word on each whole write to offset zero
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {en, sckd, fsd, idle, bcg} <= '0;
    end else if (i_awvalid && o_awready && i_wvalid && o_wready && i_awaddr == 8'h00) begin
      {en, sckd, fsd, idle, bcg} <= {i_wdata[0], i_wdata[4], i_wdata[1], i_wdata[5],
                                     i_wdata[27:16]};
    end
  end
  // one high phase of the generated bit clock with divider nine
  sequence sck_high_s;
    o_sck[*8] ##1 o_sck[*2] ##1 !o_sck;
  endsequence
  a_write_answer: assert property (
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid) else $error("no write answer");
  a_read_answer: assert property (
    i_arvalid && o_arready |=> o_rvalid) else $error("no read answer");
  a_unmapped_read: assert property (
    i_arvalid && o_arready && (i_araddr[1:0] != 2'h0 || i_araddr > 8'h2c)
    |=> o_rresp == 2'h2 && o_rdata == 32'h0) else $error("unmapped read not refused");
  a_pins_off: assert property (
    (!en)[*4] |-> o_sck_oe_b && o_sdo_oe_b && o_fs_oe_b) else $error("pin driven while off");
  a_sck_dir: assert property (
    (en && $stable(sckd))[*4] |-> o_sck_oe_b == sckd) else $error("bit clock direction");
  a_fs_dir: assert property (
    (en && $stable(fsd))[*4] |-> o_fs_oe_b == fsd) else $error("frame sync direction");
  a_sdo_drive: assert property (
    (en && !idle)[*4] |-> !o_sdo_oe_b) else $error("data out not driven");
  a_sck_period: assert property (disable iff (!i_rst_b || !en)
    $rose(o_sck) && !o_sck_oe_b && bcg == 12'h009 |-> sck_high_s) else $error("bit clock rate");
endmodule

// *** sim/csi_top_tb.sv ***
// self-checking bench for the converter serial interface top
// assumes the codec model on the pins and the checker bound to the top
`timescale 1ns/10ps
module csi_top_tb;
  logic i_clk = 1'b0; // system clock
  logic i_rst_b = 1'b0; // reset, active low
  logic [7:0] awaddr = 8'h00, araddr = 8'h00; // bus addresses
  logic [31:0] wdata = 32'h0; // write data
  // answer channels stay ready, so calls in a row never toggle them in one step
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid; // bus answers
  logic [1:0] bresp, rresp, rsp; // responses
  logic [31:0] rdata, rdv; // read data
  logic sck, sck_oe_b, sdo, sdo_oe_b, sdi, fs, fs_oe_b; // pin signals
  logic ext_sck = 1'b0, ext_run = 1'b0; // board bit clock
  wire sck_pin = sck_oe_b ? ext_sck : sck; // bit clock line
  wire fs_pin = fs_oe_b ? 1'b0 : fs; // sync line with pull-down
  logic [31:0] send = 32'h0, got; // codec words
  logic [15:0] seed = 16'h000a; // random state
  logic [15:0] tx [4]; // words placed in transmit buffers
  int n_mismatch = 0, comparisons = 0, fs_rises = 0;
  initial forever #4 i_clk = ~i_clk;
  // board clock, unrelated in phase, only while asked for
  initial begin
    #3;
    forever begin
      #80;
      if (ext_run) ext_sck = ~ext_sck;
    end
  end
  always @(posedge fs) fs_rises++;
  csi_top uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .i_sck(sck_pin), .o_sck(sck), .o_sck_oe_b(sck_oe_b),
    .o_sdo(sdo), .o_sdo_oe_b(sdo_oe_b), .i_sdi(sdi), .i_fs(fs_pin), .o_fs(fs),
    .o_fs_oe_b(fs_oe_b));
  csi_codec_model codec (.i_sck(sck_pin), .i_sdo(sdo), .i_sdo_oe_b(sdo_oe_b), .i_fs(fs_pin),
    .o_sdi(sdi), .i_send(send), .o_got(got));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // received byte as it must sit in a buffer
  function automatic logic [31:0] exp_rx(input logic [7:0] b);
    return {16'h0, b, 8'h00};
  endfunction
  // byte on the line: top of the buffer word, idle level in the unused slot
  function automatic logic [7:0] exp_tx(input logic [15:0] w, input int slot, input logic [7:0] il);
    return slot == 3 ? il : w[15:8];
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin @(posedge i_clk iff awready); awvalid <= 1'b0; end
      begin @(posedge i_clk iff wready); wvalid <= 1'b0; end
    join
    @(posedge i_clk iff bvalid);
    rsp = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge i_clk iff arready);
    arvalid <= 1'b0;
    @(posedge i_clk iff rvalid);
    rdv = rdata;
    rsp = rresp;
  endtask
  // clear receive full, then poll until a frame sets it again
  task automatic next_frame();
    wr(8'h0c, 32'h2);
    rd(8'h0c);
    for (int i = 0; i < 2000 && rdv[1] !== 1'b1; i++) rd(8'h0c);
    chk("rx full", 32'h2, rdv & 32'h2);
  endtask
  // fill buffers, run two frames, check both directions
  task automatic run_frames(input logic [31:0] c1, input logic [7:0] il);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      tx[i] = seed;
      wr(8'h20 + 8'(4 * i), {16'h0, seed});
    end
    seed = lfsr(seed);
    send[31:16] = seed;
    seed = lfsr(seed);
    send[15:0] = seed;
    wr(8'h00, c1);
    next_frame();
    next_frame();
    for (int i = 0; i < 4; i++) begin
      rd(8'h10 + 8'(4 * i));
      chk("rx buffer", exp_rx(send[31 - 8 * i -: 8]), rdv);
      chk("line word", {24'h0, exp_tx(tx[i], i, il)}, {24'h0, got[31 - 8 * i -: 8]});
    end
    wr(8'h00, 32'h0);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(8'h04);
    chk("ctrl2 reset", 32'h0000_000f, rdv);
    rd(8'h08);
    chk("ctrl3 reset", 32'h0003_ffff, rdv);
    rd(8'h30);
    chk("unmapped read", 32'h2, {30'h0, rsp});
    wr(8'h31, 32'h0);
    chk("unaligned write", 32'h2, {30'h0, rsp});
    wr(8'h04, 32'h0000_0037);
    wr(8'h08, 32'h0003_0007);
    run_frames(32'h0009_0001, 8'h00);
    ext_run <= 1'b1;
    run_frames(32'h0000_0031, 8'hff);
    ext_run <= 1'b0;
    for (int m = 1; m < 4; m++) begin
      wr(8'h00, 32'h0009_0001 | 32'(m << 2));
      fs_rises = 0;
      repeat (7000) @(posedge i_clk);
      chk("frame syncs", 32'h1, {31'h0, fs_rises != 0});
      wr(8'h00, 32'h0);
    end
    stop_test();
  end
endmodule
bind csi_top csi_top_asserts chk_i (.*);
